// ### logic/pes_pkg.sv
/*
 * Shared constants, types and helper functions for the event-select decode block.
 * Assumes a 32-bit AXI4-Lite register bus and one core clock.
 */
package pes_pkg;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_SELECT = 12'h000;
	localparam logic [11:0] OFS_CNT_LO = 12'h004;
	localparam logic [11:0] OFS_CNT_HI = 12'h008;
	localparam int SEL_CODE_LSB = 0;
	localparam int SEL_QUAL_LSB = 8;
	localparam int SEL_EDGE_BIT = 18;
	localparam int SEL_EN_BIT = 22;
	localparam int SEL_INV_BIT = 23;
	localparam int SEL_THR_LSB = 24;
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
	localparam logic [31:0] SEL_WMASK = 32'hffc4_ffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Event codes and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] EV_FP_DISPATCH = 8'h00;
	localparam logic [7:0] EV_FP_NO_RETIRE = 8'h01;
	localparam logic [7:0] EV_FP_FAST_FLAG = 8'h02;
	localparam logic [7:0] EV_SEG_LOAD = 8'h20;
	localparam logic [7:0] EV_SMC_RESTART = 8'h21;
	localparam logic [7:0] EV_PROBE_RESTART = 8'h22;
	localparam logic [7:0] EV_LSB_TWO_FULL = 8'h23;
	localparam logic [7:0] EV_LOCKED_OPS = 8'h24;
	localparam logic [7:0] EV_MEM_REQ_TYPE = 8'h65;
	localparam logic [7:0] EV_DC_ACCESS = 8'h40;
	localparam logic [7:0] EV_DC_MISS = 8'h41;
	localparam logic [7:0] EV_DC_REFILL = 8'h42;
	localparam logic [7:0] EV_DC_REFILL_SYS = 8'h43;
	localparam logic [7:0] EV_DC_EVICT = 8'h44;
	localparam logic [7:0] EV_DTLB_L2_HIT = 8'h45;
	localparam logic [7:0] EV_DTLB_MISS = 8'h46;
	localparam logic [1:0] MAX_PER_CYCLE = 2'h3;
	localparam logic [7:0] THR_MAX = 8'h03;
	localparam int QUAL_UC = 0;
	localparam int QUAL_WC = 1;
	localparam int QUAL_SS = 7;

	// Per-cycle occurrences from pipelines, caches and TLBs
	typedef struct packed {
		logic [5:0] fp_disp;
		logic [5:0] fp_packed;
		logic fp_retired;
		logic [1:0] fp_fast;
		logic [6:0] seg_load;
		logic smc_restart;
		logic probe_restart;
		logic lsb_two_full;
		logic [2:0] lock;
		logic mem_uc;
		logic mem_wc_flush;
		logic mem_ss_flush;
		logic [1:0] dc_access;
		logic dc_miss_first;
		logic [1:0] dc_miss_stream;
		logic [4:0] dc_refill;
		logic [4:0] dc_refill_sys;
		logic [4:0] dc_evict;
		logic dtlb_l2_hit;
		logic dtlb_miss;
	} pes_src_t;

	// Number of set bits in a byte
	function automatic logic [3:0] pes_popcount(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

endpackage

// ### logic/pes_sel_if.sv
/*
 * Selection and occurrence carrier between the core and the decoder.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/1ps
interface pes_sel_if;
	import pes_pkg::*;
	logic [7:0] code;
	logic [7:0] qual;
	pes_src_t src;
	logic [1:0] occ;
	modport core (output code, output qual, output src, input occ);
	modport decode (input code, input qual, input src, output occ);
endinterface

// ### logic/pes_decode.sv
/*
 * Combinational event decoder: selected occurrences per cycle, 0 to 3.
 * Assumes the source bits are per-cycle pulses or levels from the core clock.
 */
`timescale 1ns/1ps
module pes_decode (
	pes_sel_if.decode sel
);
	import pes_pkg::*;

	logic [3:0] raw;
	pes_src_t s;
	logic [7:0] q;

	assign s = sel.src;
	assign q = sel.qual;

	// ----------------------------------------------------------------
	// Event multiplexer
	// ----------------------------------------------------------------
	// Masked sub-events are summed; unknown codes give nothing
	always_comb begin
		raw = 4'h0;
		case (sel.code)
			EV_FP_DISPATCH: begin
				raw = pes_popcount({2'h0, s.fp_disp & q[5:0]})
					+ pes_popcount({2'h0, s.fp_disp & s.fp_packed & q[5:0]});
			end
			EV_FP_NO_RETIRE: raw = {3'h0, ~s.fp_retired};
			EV_FP_FAST_FLAG: raw = {2'h0, s.fp_fast};
			EV_SEG_LOAD: raw = pes_popcount({1'h0, s.seg_load & q[6:0]});
			EV_SMC_RESTART: raw = {3'h0, s.smc_restart};
			EV_PROBE_RESTART: raw = {3'h0, s.probe_restart};
			EV_LSB_TWO_FULL: raw = {3'h0, s.lsb_two_full};
			EV_LOCKED_OPS: raw = pes_popcount({5'h0, s.lock & q[2:0]});
			EV_MEM_REQ_TYPE: begin
				raw = pes_popcount({q[QUAL_SS] & s.mem_ss_flush, 5'h0,
					q[QUAL_WC] & s.mem_wc_flush, q[QUAL_UC] & s.mem_uc});
			end
			EV_DC_ACCESS: raw = {2'h0, s.dc_access};
			EV_DC_MISS: raw = {3'h0, s.dc_miss_first} + {2'h0, s.dc_miss_stream};
			EV_DC_REFILL: raw = pes_popcount({3'h0, s.dc_refill & q[4:0]});
			EV_DC_REFILL_SYS: raw = pes_popcount({3'h0, s.dc_refill_sys & q[4:0]});
			EV_DC_EVICT: raw = pes_popcount({3'h0, s.dc_evict & q[4:0]});
			EV_DTLB_L2_HIT: raw = {3'h0, s.dtlb_l2_hit};
			EV_DTLB_MISS: raw = {3'h0, s.dtlb_miss};
			default: raw = 4'h0;
		endcase
	end

	// Clamp to the per-cycle limit
	assign sel.occ = (raw > {2'h0, MAX_PER_CYCLE}) ? MAX_PER_CYCLE : raw[1:0];

endmodule

// ### logic/pes_top.sv
/*
 * Performance counter with event-select decode, reached over AXI4-Lite.
 * Assumes event inputs are synchronous to SYS_CLK and a well-behaved AXI4-Lite master.
 */

// How it works
// - Code 00h counts FP dispatches; qualifier bits 01h-20h pick pipes and load forms.
// - A packed 128-bit FP dispatch adds two, a scalar one adds one.
// - Code 01h counts cycles with no FP retire; inversion counts cycles with retires.
// - Code 02h counts fast-flag FP operations, speculative included.
// - Code 20h counts segment loads; qualifier bits 01h-40h pick seven registers.
// - Code 21h counts restarts from stores hitting already fetched younger instructions.
// - Code 22h counts restarts from invalidating probes hitting speculative loads.
// - Code 23h counts cycles in which the second load/store buffer is full.
// - Code 24h: 01h locked instructions, 02h speculative cycles, 04h non-speculative cycles.
// - Code 65h counts uncachable requests, write-combining flushes and streaming-store flushes.
// - Code 40h counts each eight-byte data cache access, speculative included.
// - Code 41h counts only the first miss to a line while its refill pends.
// - Code 41h counts every streaming store miss individually.
// - Code 42h: bit 0 refills from system, bits 4:1 second-level refills by state.
// - Code 43h counts system refills; bits 01h-10h pick invalid through modified.
// - Code 44h counts written-back victim lines, selected by victim coherency state.
// - Code 45h counts first-level data TLB misses that hit second level.
// - Code 46h counts data accesses missing both data TLB levels.
// - Several qualifier bits together monitor all selected sub-events at once.
// - Zero threshold adds the number of selected events per cycle, at most 3.
// - Bit 18 set counts rising edges of the condition, clear counts its level.
`timescale 1ns/1ps
module pes_top #(
	parameter int CNT_W = 48
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [pes_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [pes_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [5:0] FP_DISPATCH,
	input wire logic [5:0] FP_DISPATCH_PACKED,
	input wire logic FP_RETIRED,
	input wire logic [1:0] FP_FAST_FLAG,
	input wire logic [6:0] SEG_LOAD,
	input wire logic SMC_RESTART,
	input wire logic PROBE_RESTART,
	input wire logic LOAD_STORE_BUFFER_TWO_FULL,
	input wire logic LOCK_EXEC,
	input wire logic LOCK_SPEC_CYCLE,
	input wire logic LOCK_NONSPEC_CYCLE,
	input wire logic MEM_UC_REQ,
	input wire logic MEM_WC_FLUSH,
	input wire logic MEM_SS_FLUSH,
	input wire logic [1:0] DC_ACCESS,
	input wire logic DC_MISS_FIRST,
	input wire logic [1:0] DC_MISS_STREAM,
	input wire logic [4:0] DC_REFILL,
	input wire logic [4:0] DC_REFILL_SYS,
	input wire logic [4:0] DC_EVICT,
	input wire logic DTLB_L2_HIT,
	input wire logic DTLB_MISS,
	output logic [CNT_W-1:0] PERFORMANCE_COUNTER
);
	import pes_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// Software-visible state
	logic [31:0] event_select;
	logic [CNT_W-1:0] performance_counter;

	// Write address and data held until both are in
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Register strobes of a complete write
	logic write_go;
	logic wr_select;
	logic wr_cnt_lo;
	logic wr_cnt_hi;

	// Merged write values and the upper counter word
	logic [31:0] cnt_hi_word;
	logic [31:0] next_select;
	logic [31:0] next_cnt_lo;
	logic [31:0] next_cnt_hi;

	// Read path
	logic [31:0] read_word;
	logic read_hit;

	// Counting controls and per-cycle step
	logic [7:0] count_threshold;
	logic invert_threshold;
	logic edge_mode;
	logic count_enable;
	logic [1:0] level_inc;
	logic cond_now;
	logic cond_prev;
	logic [1:0] step;

	pes_sel_if sel ();

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Word address of a byte address; the two low bits are ignored
	function automatic logic [ADDR_W-1:0] pes_word_addr(input logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:2], 2'h0};
	endfunction

	// True for a word address that holds a register
	function automatic logic pes_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		case (a)
			OFS_SELECT, OFS_CNT_LO, OFS_CNT_HI: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] pes_merge(input logic [31:0] old_word, input logic [31:0] new_word,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Decoder
	// ----------------------------------------------------------------
	// Bundle the occurrence inputs for the decoder
	assign sel.code = event_select[SEL_CODE_LSB +: 8];
	assign sel.qual = event_select[SEL_QUAL_LSB +: 8];
	always_comb begin
		sel.src = '0;
		sel.src.fp_disp = FP_DISPATCH;
		sel.src.fp_packed = FP_DISPATCH_PACKED;
		sel.src.fp_retired = FP_RETIRED;
		sel.src.fp_fast = FP_FAST_FLAG;
		sel.src.seg_load = SEG_LOAD;
		sel.src.smc_restart = SMC_RESTART;
		sel.src.probe_restart = PROBE_RESTART;
		sel.src.lsb_two_full = LOAD_STORE_BUFFER_TWO_FULL;
		sel.src.lock = {LOCK_NONSPEC_CYCLE, LOCK_SPEC_CYCLE, LOCK_EXEC};
		sel.src.mem_uc = MEM_UC_REQ;
		sel.src.mem_wc_flush = MEM_WC_FLUSH;
		sel.src.mem_ss_flush = MEM_SS_FLUSH;
		sel.src.dc_access = DC_ACCESS;
		sel.src.dc_miss_first = DC_MISS_FIRST;
		sel.src.dc_miss_stream = DC_MISS_STREAM;
		sel.src.dc_refill = DC_REFILL;
		sel.src.dc_refill_sys = DC_REFILL_SYS;
		sel.src.dc_evict = DC_EVICT;
		sel.src.dtlb_l2_hit = DTLB_L2_HIT;
		sel.src.dtlb_miss = DTLB_MISS;
	end

	pes_decode u_decode (
		.sel(sel.decode)
	);

	// ----------------------------------------------------------------
	// Threshold, inversion and edge detect
	// ----------------------------------------------------------------
	// Fields of the event-select word
	assign count_threshold = event_select[SEL_THR_LSB +: 8];
	assign invert_threshold = event_select[SEL_INV_BIT];
	assign edge_mode = event_select[SEL_EDGE_BIT];
	assign count_enable = event_select[SEL_EN_BIT];

	// Per-cycle increment in level mode
	always_comb begin
		level_inc = 2'h0;
		if (count_threshold == 8'h00) begin
			if (invert_threshold) begin
				level_inc = (sel.occ == 2'h0) ? 2'h1 : 2'h0;
			end else begin
				level_inc = sel.occ;
			end
		end else if (count_threshold <= THR_MAX) begin
			if (invert_threshold) begin
				level_inc = ({6'h0, sel.occ} < count_threshold) ? 2'h1 : 2'h0;
			end else begin
				level_inc = ({6'h0, sel.occ} >= count_threshold) ? 2'h1 : 2'h0;
			end
		end else begin
			level_inc = 2'h0; // Reserved thresholds count nothing
		end
	end

	// Condition and step; edge mode adds one on a rising condition
	assign cond_now = (level_inc != 2'h0);
	assign step = edge_mode ? {1'h0, cond_now & ~cond_prev} : level_inc;

	// Previous condition for edge detection
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cond_prev <= 1'b0;
		end else begin
			cond_prev <= cond_now;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Each ready while its own channel holds nothing and no answer waits
	assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
	assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;

	// Register strobes once address and data are both in
	assign write_go = aw_held & w_held;
	assign wr_select = write_go & (aw_addr == OFS_SELECT);
	assign wr_cnt_lo = write_go & (aw_addr == OFS_CNT_LO);
	assign wr_cnt_hi = write_go & (aw_addr == OFS_CNT_HI);

	// Hold the write address until its data is also in
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held <= 1'b1;
			aw_addr <= pes_word_addr(S_AXI_AWADDR);
		end else if (write_go) begin
			aw_held <= 1'b0;
		end
	end

	// Hold the write data until its address is also in
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (write_go) begin
			w_held <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with an error
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (write_go) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= pes_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Next values: byte-lane merge into the current contents
	assign cnt_hi_word = {{(64-CNT_W){1'b0}}, performance_counter[CNT_W-1:32]};
	assign next_select = pes_merge(event_select, w_data, w_strb) & SEL_WMASK;
	assign next_cnt_lo = pes_merge(performance_counter[31:0], w_data, w_strb);
	assign next_cnt_hi = pes_merge(cnt_hi_word, w_data, w_strb);

	// Event-select register
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			event_select <= SEL_RESET;
		end else if (wr_select) begin
			event_select <= next_select;
		end
	end

	// Counter: a software load wins over a count in the same cycle
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			performance_counter <= '0;
		end else if (wr_cnt_lo) begin
			performance_counter[31:0] <= next_cnt_lo;
		end else if (wr_cnt_hi) begin
			performance_counter[CNT_W-1:32] <= next_cnt_hi[CNT_W-33:0];
		end else if (count_enable) begin
			performance_counter <= performance_counter + CNT_W'(step);
		end
	end

	// Counter output straight from its register
	assign PERFORMANCE_COUNTER = performance_counter;

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	// A new read is taken once the last answer is gone
	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	// Read multiplexer
	always_comb begin
		read_word = 32'h0000_0000;
		read_hit = pes_mapped(pes_word_addr(S_AXI_ARADDR));
		case (pes_word_addr(S_AXI_ARADDR))
			OFS_SELECT: read_word = event_select;
			OFS_CNT_LO: read_word = performance_counter[31:0];
			OFS_CNT_HI: read_word = cnt_hi_word;
			default: read_word = 32'h0000_0000;
		endcase
	end

	// Registered read answer
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= read_word;
			S_AXI_RRESP <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule

// ### bench/pes_src_model.sv
/*
 * Model of the pipeline, cache and TLB event sources feeding pes_top.
 * Assumes the bench loads a pattern and pulses go once per burst.
 */
`timescale 1ns/1ps
module pes_src_model (
	input wire logic clk,
	input wire logic rst,
	input wire pes_pkg::pes_src_t pat,
	input wire logic [7:0] len,
	input wire logic go,
	output pes_pkg::pes_src_t src
);
	import pes_pkg::*;
	logic [7:0] left;

	// ----------------------------------------------------------------
	// Burst timing
	// ----------------------------------------------------------------
	// Cycles left in the burst, restarted by go
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left <= 8'h00;
		end else if (go) begin
			left <= len;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end

	// Occurrences only inside a burst; idle lines mean no event
	assign src = (left != 8'h00) ? pat : '0;
endmodule

// ### bench/pes_top_monitor.sv
/*
 * Bus handshake and count-step checker bound into pes_top.
 * Assumes one clock domain and the top module's own port names.
 */
`timescale 1ns/1ps
module pes_top_monitor #(
	parameter int CNT_W = 48
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [CNT_W-1:0] PERFORMANCE_COUNTER
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	// ----------------------------------------------------------------
	// Bus transfers
	// ----------------------------------------------------------------
	sequence aw_taken;
		S_AXI_AWVALID && S_AXI_AWREADY;
	endsequence
	sequence w_taken;
		S_AXI_WVALID && S_AXI_WREADY;
	endsequence

	write_answer_a: assert property (aw_taken and w_taken |=> ##1 S_AXI_BVALID) else $error("write answer late");
	read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
	aw_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("ready while busy");
	ar_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("arready while busy");
	bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer dropped");
	bvalid_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid stuck");
	rvalid_drop_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid stuck");

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	count_step_a: assert property (!$rose(S_AXI_BVALID) |-> (PERFORMANCE_COUNTER - $past(PERFORMANCE_COUNTER)) <= 3)
		else $error("counter step above three");
endmodule

bind pes_top pes_top_monitor #(.CNT_W(CNT_W)) u_mon (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY), .PERFORMANCE_COUNTER(PERFORMANCE_COUNTER));

// ### bench/perf_event_select_decode_bench.sv
/*
 * Self-checking bench: register access, then one event burst per selection.
 * Assumes the source model drives four-cycle bursts and a 250 MHz clock.
 */
`timescale 1ns/1ps
module perf_event_select_decode_bench;
	import pes_pkg::*;
	logic clk = 1'b0, rst = 1'b1, go = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic [47:0] cnt;
	pes_src_t p = '0, pat = '0, src;
	int miscompares = 0, tests_run = 0, cyc = 0;

	// ----------------------------------------------------------------
	// Clock, design and event sources
	// ----------------------------------------------------------------
	always #2 clk = ~clk;

	pes_top #(.CNT_W(48)) i_dut (.SYS_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FP_DISPATCH(src.fp_disp),
		.FP_DISPATCH_PACKED(src.fp_packed), .FP_RETIRED(src.fp_retired), .FP_FAST_FLAG(src.fp_fast),
		.SEG_LOAD(src.seg_load), .SMC_RESTART(src.smc_restart), .PROBE_RESTART(src.probe_restart),
		.LOAD_STORE_BUFFER_TWO_FULL(src.lsb_two_full), .LOCK_EXEC(src.lock[0]), .LOCK_SPEC_CYCLE(src.lock[1]),
		.LOCK_NONSPEC_CYCLE(src.lock[2]), .MEM_UC_REQ(src.mem_uc), .MEM_WC_FLUSH(src.mem_wc_flush),
		.MEM_SS_FLUSH(src.mem_ss_flush), .DC_ACCESS(src.dc_access), .DC_MISS_FIRST(src.dc_miss_first),
		.DC_MISS_STREAM(src.dc_miss_stream), .DC_REFILL(src.dc_refill), .DC_REFILL_SYS(src.dc_refill_sys),
		.DC_EVICT(src.dc_evict), .DTLB_L2_HIT(src.dtlb_l2_hit), .DTLB_MISS(src.dtlb_miss),
		.PERFORMANCE_COUNTER(cnt));

	pes_src_model i_src (.clk(clk), .rst(rst), .pat(pat), .len(8'h04), .go(go), .src(src));

	// ----------------------------------------------------------------
	// Bus tasks and comparisons
	// ----------------------------------------------------------------
	// Address and data offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t response %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t counter %h expected %h", $time, got, exp);
		end
	endtask

	// Clear, select with enable, one four-cycle burst of p, stop, read count
	task automatic run(input logic [31:0] sel, input logic [31:0] exp);
		axi_wr(OFS_SELECT, 32'h0, r);
		axi_wr(OFS_CNT_LO, 32'h0, r);
		axi_wr(OFS_SELECT, sel | 32'h0040_0000, r);
		@(posedge clk);
		pat <= p;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (8) @(posedge clk);
		axi_wr(OFS_SELECT, 32'h0, r);
		axi_rd(OFS_CNT_LO, d, r);
		chk_data(d, exp);
		chk_cnt(cnt, {16'h0, exp});
		p = '0;
	endtask

	task automatic finish_test();
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		axi_rd(OFS_SELECT, d, r);
		chk_data(d, SEL_RESET);
		chk_resp(r, RESP_OKAY);
		axi_wr(OFS_SELECT, 32'hffff_ffff, r);
		chk_resp(r, RESP_OKAY);
		axi_rd(OFS_SELECT, d, r);
		chk_data(d, SEL_WMASK);
		axi_wr(OFS_CNT_HI, 32'hffff_ffff, r);
		axi_rd(OFS_CNT_HI, d, r);
		chk_data(d, 32'h0000_ffff);
		axi_wr(OFS_CNT_HI, 32'h0, r);
		axi_wr(12'h00c, 32'h1, r);
		chk_resp(r, RESP_SLVERR);
		axi_rd(12'h00c, d, r);
		chk_resp(r, RESP_SLVERR);
		chk_data(d, 32'h0);
		p.fp_disp = 6'h01;
		run(32'h0100, 32'd4);
		p.fp_disp = 6'h20;
		run(32'h2000, 32'd4);
		p.fp_disp = 6'h01;
		p.fp_packed = 6'h01;
		run(32'h0100, 32'd8);
		p.fp_disp = 6'h3f;
		run(32'h3f00, 32'd12);
		p.fp_disp = 6'h07;
		run(32'h0200_3f00, 32'd4);
		p.fp_disp = 6'h07;
		run(32'h0400_3f00, 32'd0);
		p.fp_retired = 1'b1;
		run(32'h0080_0001, 32'd4);
		p.fp_fast = 2'h2;
		run(32'h0002, 32'd8);
		p.seg_load = 7'h40;
		run(32'h4020, 32'd4);
		p.seg_load = 7'h40;
		run(32'h0120, 32'd0);
		p.smc_restart = 1'b1;
		run(32'h0021, 32'd4);
		p.probe_restart = 1'b1;
		run(32'h0022, 32'd4);
		p.lsb_two_full = 1'b1;
		run(32'h0023, 32'd4);
		p.lsb_two_full = 1'b1;
		run(32'h0004_0023, 32'd1);
		p.lock = 3'h2;
		run(32'h0224, 32'd4);
		p.lock = 3'h7;
		run(32'h0524, 32'd8);
		p.lock = 3'h7;
		run(32'hf824, 32'd0);
		p.mem_uc = 1'b1;
		p.mem_wc_flush = 1'b1;
		p.mem_ss_flush = 1'b1;
		run(32'h8365, 32'd12);
		p.mem_ss_flush = 1'b1;
		run(32'h8065, 32'd4);
		p.dc_access = 2'h2;
		run(32'h0040, 32'd8);
		p.dc_miss_first = 1'b1;
		p.dc_miss_stream = 2'h2;
		run(32'h0041, 32'd12);
		p.dc_refill = 5'h1f;
		run(32'h0142, 32'd4);
		p.dc_refill = 5'h10;
		run(32'h1042, 32'd4);
		p.dc_refill_sys = 5'h03;
		run(32'h1f43, 32'd8);
		p.dc_evict = 5'h18;
		run(32'h0844, 32'd4);
		p.dtlb_l2_hit = 1'b1;
		run(32'h0045, 32'd4);
		p.dtlb_miss = 1'b1;
		run(32'h0046, 32'd4);
		p = '1;
		run(32'hff7f, 32'd0);
		finish_test();
	end
endmodule
